// ===== verilog/timer_mode_ctrl.sv
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module timer_mode_ctrl
  import timer_mode_pkg::*;
(
  // Clock, reset, standby
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic standby,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Quadrature pins
  input wire logic ext_clock_in_a,
  input wire logic ext_clock_in_b,
  // From counters and compare logic
  input wire logic [timer_mode_pkg::NUM_CH-1:0] clear_request,
  input wire logic [timer_mode_pkg::NUM_CH-1:0] preset_request,
  input wire logic [timer_mode_pkg::NUM_CH-1:0] compare_match_a,
  input wire logic [timer_mode_pkg::NUM_CH-1:0] compare_match_b,
  input wire logic ch2_prescaled_tick,
  input wire logic ch2_overflow,
  input wire logic ch2_underflow,
  input wire logic [1:0] combination_mode,
  // To counters
  output logic [timer_mode_pkg::NUM_CH-1:0] counter_clear,
  output logic [timer_mode_pkg::NUM_CH-1:0] counter_preset,
  output logic ch2_count_up,
  output logic ch2_count_down,
  output logic ch2_overflow_set,
  output logic ch2_use_external,
  // Pulse pins
  output logic [timer_mode_pkg::NUM_CH-1:0] pulse_pin,
  output logic [timer_mode_pkg::NUM_CH-1:0] pulse_pin_oe,
  // Interrupt
  output logic irq
);
  import timer_mode_pkg::*;

  logic [4:0] channel_sync_select;
  logic [6:0] timer_mode_select;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [7:0] sync_view;
  logic [7:0] mode_view;
  logic quadrature_mode_flag;
  logic overflow_flag_condition;
  logic combined_pwm;
  logic [NUM_CH-1:0] pulse_mode;
  logic access;
  logic wr;
  logic hit_sync;
  logic hit_mode;
  logic hit_status;
  logic hit_mask;
  logic mapped;
  logic [31:0] read_mux;
  logic any_sync_clear;
  logic any_sync_preset;
  logic [NUM_CH-1:0] next_clear;
  logic [NUM_CH-1:0] next_preset;
  logic next_overflow;
  logic [1:0] irq_event;
  logic [1:0] next_status;
  logic init;

  quad_if qd();

  quad_decoder u_quad
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ext_clock_in_a(ext_clock_in_a),
    .ext_clock_in_b(ext_clock_in_b),
    .q(qd.dec)
  );

  // ==========================================
  // Bus decode
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign hit_sync = (paddr == SYNC_ADDR);
  assign hit_mode = (paddr == MODE_ADDR);
  assign hit_status = (paddr == IRQ_STATUS_ADDR);
  assign hit_mask = (paddr == IRQ_MASK_ADDR);
  assign mapped = hit_sync | hit_mode | hit_status | hit_mask;
  assign init = !rst_b || standby;

  assign sync_view = SYNC_FIXED | {3'h0, channel_sync_select}; // [R16]
  assign mode_view = MODE_FIXED | {1'b0, timer_mode_select}; // [R4]
  assign read_mux = hit_sync ? {24'h000000, sync_view} :
                    hit_mode ? {24'h000000, mode_view} :
                    hit_status ? {30'h00000000, irq_status} :
                    hit_mask ? {30'h00000000, irq_mask} : 32'h00000000;

  // ==========================================
  // Control registers
  always_ff @(posedge clk_sys)
  begin
    if (init)
    begin
      channel_sync_select <= SYNC_RESET[4:0]; // [R16]
      timer_mode_select <= MODE_RESET[6:0]; // [R3]
      irq_mask <= IRQ_RESET;
    end
    else if (wr)
    begin
      if (hit_sync)
        channel_sync_select <= pwdata[4:0];
      if (hit_mode)
        timer_mode_select <= pwdata[6:0]; // [R4]
      if (hit_mask)
        irq_mask <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= (psel & ~penable & ~pwrite) ? read_mux : 32'h00000000;
    end
  end

  // ==========================================
  // Mode fields
  assign quadrature_mode_flag = timer_mode_select[MODE_QUAD_BIT]; // [R5]
  assign overflow_flag_condition = timer_mode_select[MODE_FLAG_COND_BIT];
  assign combined_pwm = combination_mode[CMB_PWM_BIT];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      if (ch == PWM_CH3 || ch == PWM_CH4)
      begin : g_cmb
        assign pulse_mode[ch] = timer_mode_select[ch] & ~combined_pwm; // [R11] [R12] [R13] [R14]
      end
      else
      begin : g_plain
        assign pulse_mode[ch] = timer_mode_select[ch]; // [R11] [R15]
      end
      assign next_clear[ch] = channel_sync_select[ch] ? any_sync_clear : clear_request[ch]; // [R1] [R2]
      assign next_preset[ch] = channel_sync_select[ch] ? any_sync_preset : preset_request[ch]; // [R1] [R2]

      // Pin set on match A, cleared on match B; B wins on a tie
      always_ff @(posedge clk_sys)
      begin
        if (init)
        begin
          pulse_pin[ch] <= 1'b0;
          pulse_pin_oe[ch] <= 1'b0;
        end
        else
        begin
          pulse_pin_oe[ch] <= pulse_mode[ch];
          if (pulse_mode[ch] && compare_match_b[ch])
            pulse_pin[ch] <= 1'b0; // [R12] [R13] [R15]
          else if (pulse_mode[ch] && compare_match_a[ch])
            pulse_pin[ch] <= 1'b1; // [R12] [R13] [R15]
        end
      end
    end
  endgenerate

  // ==========================================
  // Synchronous clear and preset
  assign any_sync_clear = |(clear_request & channel_sync_select); // [R2]
  assign any_sync_preset = |(preset_request & channel_sync_select); // [R2]

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      counter_clear <= '0;
      counter_preset <= '0;
    end
    else
    begin
      counter_clear <= next_clear; // [R9]
      counter_preset <= next_preset;
    end
  end

  // ==========================================
  // Channel 2 count source and overflow flag
  assign next_overflow = ch2_overflow | (ch2_underflow & ~overflow_flag_condition); // [R10]

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      ch2_count_up <= 1'b0;
      ch2_count_down <= 1'b0;
      ch2_overflow_set <= 1'b0;
      ch2_use_external <= 1'b0;
    end
    else
    begin
      ch2_use_external <= quadrature_mode_flag;
      ch2_count_up <= quadrature_mode_flag ? qd.up : ch2_prescaled_tick; // [R6] [R8]
      ch2_count_down <= quadrature_mode_flag & qd.down; // [R6] [R7]
      ch2_overflow_set <= next_overflow; // [R9] [R10]
    end
  end

  // ==========================================
  // Interrupt status, write one to clear, set wins
  assign irq_event[IRQ_OVERFLOW_BIT] = next_overflow;
  assign irq_event[IRQ_QERR_BIT] = quadrature_mode_flag & qd.err;
  assign next_status = irq_event | (irq_status & ~((wr && hit_status) ? pwdata[1:0] : 2'h0));

  always_ff @(posedge clk_sys)
  begin
    if (init)
    begin
      irq_status <= IRQ_RESET;
      irq <= 1'b0;
    end
    else
    begin
      irq_status <= next_status;
      irq <= |(next_status & irq_mask);
    end
  end

endmodule
`default_nettype wire

// ===== verilog/timer_mode_pkg.sv
// Behaviour
// R1 - Sync bit 0: channel presets/clears alone
// R2 - Sync bit 1: synced channels preset/clear together
// R3 - Mode register resets to 80h, also standby
// R4 - Mode bit 7 ignores writes, reads 1
// R5 - Mode bit 6 selects channel 2 quadrature
// R6 - Quadrature counts both edges of both pins
// R7 - Direction follows input phase order, one/edge
// R8 - Quadrature ignores edge and prescaler selection
// R9 - Channel 2 clear, compare, flags stay active
// R10 - Mode bit 5: overflow only or both
// R11 - Mode bits 4..0 select pulse mode
// R12 - Channel 4 pin: A match high, B low
// R13 - Channel 3 pin: A match high, B low
// R14 - Combination PWM modes override channel 3/4 bits
// R15 - Channels 2,1,0 pins follow same scheme
// R16 - Sync register resets E0h, top bits one
// R17 - Software never syncs 3 and 4 in complementary
package timer_mode_pkg;

  localparam int NUM_CH = 5;

  // ==========================================
  // Register byte addresses
  localparam logic [7:0] SYNC_ADDR = 8'h00;
  localparam logic [7:0] MODE_ADDR = 8'h04;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h08;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h0C;

  // ==========================================
  // Reset values and fixed bits
  localparam logic [7:0] SYNC_RESET = 8'hE0;
  localparam logic [7:0] SYNC_FIXED = 8'hE0;
  localparam logic [7:0] MODE_RESET = 8'h80;
  localparam logic [7:0] MODE_FIXED = 8'h80;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ==========================================
  // Mode register fields
  localparam int MODE_QUAD_BIT = 6;
  localparam int MODE_FLAG_COND_BIT = 5;
  localparam int PWM_CH3 = 3;
  localparam int PWM_CH4 = 4;

  // ==========================================
  // Interrupt status fields
  localparam int IRQ_OVERFLOW_BIT = 0;
  localparam int IRQ_QERR_BIT = 1;

  // Combination mode codes: 1x is a combined pulse mode
  localparam int CMB_PWM_BIT = 1;

endpackage

// ===== verilog/quad_if.sv
`timescale 1ns/1ns
`default_nettype none
interface quad_if;
  logic up;
  logic down;
  logic err;
  modport dec(output up, output down, output err);
  modport ctl(input up, input down, input err);
endinterface
`default_nettype wire

// ===== verilog/quad_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module quad_decoder
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Pins
  input wire logic ext_clock_in_a,
  input wire logic ext_clock_in_b,
  // Decoded steps
  quad_if.dec q
);

  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic stable_a;
  logic stable_b;
  logic next_a;
  logic next_b;
  logic change_a;
  logic change_b;

  // ==========================================
  // Three-stage synchronisers, change taken when stages two and three agree
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end
    else
    begin
      sync_a <= {sync_a[1:0], ext_clock_in_a};
      sync_b <= {sync_b[1:0], ext_clock_in_b};
    end
  end

  assign next_a = (sync_a[1] == sync_a[2]) ? sync_a[2] : stable_a;
  assign next_b = (sync_b[1] == sync_b[2]) ? sync_b[2] : stable_b;
  assign change_a = next_a ^ stable_a;
  assign change_b = next_b ^ stable_b;

  // ==========================================
  // Step decode
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      stable_a <= 1'b0;
      stable_b <= 1'b0;
      q.up <= 1'b0;
      q.down <= 1'b0;
      q.err <= 1'b0;
    end
    else
    begin
      stable_a <= next_a;
      stable_b <= next_b;
      q.up <= (change_a ^ change_b) & (stable_a ^ next_b); // [R6] [R7]
      q.down <= (change_a ^ change_b) & ~(stable_a ^ next_b); // [R6] [R7]
      q.err <= change_a & change_b;
    end
  end

endmodule
`default_nettype wire

// ===== testbench/timer_mode_ctrl_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module timer_mode_ctrl_assertions
  import timer_mode_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic standby,
  // Bus
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Timer
  input wire logic [4:0] clear_request,
  input wire logic [4:0] counter_clear,
  input wire logic [4:0] compare_match_a,
  input wire logic [4:0] compare_match_b,
  input wire logic ch2_overflow,
  input wire logic ch2_overflow_set,
  input wire logic ch2_use_external,
  input wire logic ch2_count_down,
  input wire logic [1:0] combination_mode,
  input wire logic [4:0] pulse_pin,
  input wire logic [4:0] pulse_pin_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_mode_top_set: assert property (psel && penable && pready && !pwrite && paddr == MODE_ADDR |-> prdata[7])
    else $error("mode bit 7 low");
  a_clear_own: assert property (clear_request != 0 |=> (counter_clear & $past(clear_request)) == $past(clear_request))
    else $error("clear lost");
  a_pin_set_ch4: assert property (compare_match_a[4] && !compare_match_b[4] && pulse_pin_oe[4] |=> pulse_pin[4])
    else $error("ch4 pin not set");
  a_pin_low_ch3: assert property (compare_match_b[3] && pulse_pin_oe[3] |=> !pulse_pin[3])
    else $error("ch3 pin not low");
  a_cmb_wins: assert property (combination_mode[1] [*2] |-> pulse_pin_oe[4:3] == 2'h0)
    else $error("pulse bits not overridden");
  a_overflow_flag: assert property (ch2_overflow |=> ch2_overflow_set)
    else $error("overflow not flagged");
  a_standby_init: assert property (standby |-> ##2 pulse_pin_oe == 5'h00 && !ch2_use_external)
    else $error("standby left modes");
  a_normal_no_down: assert property (!ch2_use_external [*8] |-> !ch2_count_down)
    else $error("down count in normal mode");
endmodule
bind timer_mode_ctrl timer_mode_ctrl_assertions u_chk (.*);
`default_nettype wire

// ===== testbench/quad_encoder_model.sv
`timescale 1ns/1ns
`default_nettype none
module quad_encoder_model
(
  // Clock and step: 1 up, 2 down, 3 both pins at once
  input wire logic clk_sys,
  input wire logic [1:0] step,
  // Encoder pins
  output logic ext_clock_in_a,
  output logic ext_clock_in_b
);
  logic [1:0] phase = 2'h0;
  always @(posedge clk_sys)
    phase <= phase + (step == 2'h2 ? 2'h3 : step == 2'h3 ? 2'h2 : step);
  // Gray order: one pin moves per up or down step
  assign ext_clock_in_a = phase[1];
  assign ext_clock_in_b = phase[1] ^ phase[0];
endmodule
`default_nettype wire

// ===== testbench/timer_mode_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; $display("ERROR %0t bad %h", $time, a); end end
`define WAIT(c) begin n = 0; do @(negedge clk_sys); while (!(c) && n++ < 20); limit(); end
`define PULSE(s, v) begin @(posedge clk_sys); s <= v; @(posedge clk_sys); s <= '0; end
module timer_mode_ctrl_tb;
  import timer_mode_pkg::*;
  logic clk_sys = 0, rst_b = 0, standby = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, ext_clock_in_a, ext_clock_in_b, ch2_count_up, ch2_count_down, irq;
  logic [4:0] clear_request = '0, preset_request = '0, compare_match_a = '0, compare_match_b = '0;
  logic [4:0] counter_clear, counter_preset, pulse_pin, pulse_pin_oe;
  logic ch2_prescaled_tick = 0, ch2_overflow = 0, ch2_underflow = 0, ch2_overflow_set, ch2_use_external;
  logic [1:0] combination_mode = '0, step = '0;
  int error_cnt = 0, n_compared = 0, n;
  timer_mode_ctrl dut (.*);
  quad_encoder_model enc (.*);
  always #25 clk_sys = ~clk_sys;
  // ==========
  // Helpers
  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic limit;
    n_compared++;
    if (n >= 20)
    begin
      error_cnt++;
      $display("ERROR %0t timeout", $time);
      final_report();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    // Sample the answer at the rising edge itself
    n = 0;
    do @(posedge clk_sys); while (pready !== 1'b1 && n++ < 20);
    limit();
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    `CHK(rd, e)
  endtask
  // ==========
  // Scenarios
  task automatic t_regs;
    rchk(SYNC_ADDR, 32'hE0);
    rchk(MODE_ADDR, 32'h80);
    apb(1, MODE_ADDR, 32'h0);
    rchk(MODE_ADDR, 32'h80);
    apb(1, 8'h10, 32'hFF);
    `CHK(er, 1'b1)
  endtask
  task automatic t_sync;
    apb(1, SYNC_ADDR, 32'h0A);
    `PULSE(clear_request, 5'h02)
    `WAIT(counter_clear != 0)
    `CHK(counter_clear, 5'h0A)
    `PULSE(preset_request, 5'h01)
    `WAIT(counter_preset != 0)
    `CHK(counter_preset, 5'h01)
  endtask
  task automatic t_irq;
    apb(1, MODE_ADDR, 32'h20);
    `PULSE(ch2_underflow, 1'b1)
    rchk(MODE_ADDR, 32'hA0);
    rchk(IRQ_STATUS_ADDR, 32'h0);
    `PULSE(ch2_overflow, 1'b1)
    apb(1, IRQ_MASK_ADDR, 32'h1);
    `WAIT(irq)
    apb(1, IRQ_MASK_ADDR, 32'h0);
    `WAIT(!irq)
    apb(1, IRQ_STATUS_ADDR, 32'h1);
    apb(1, MODE_ADDR, 32'h0);
    `PULSE(ch2_underflow, 1'b1)
    apb(1, IRQ_MASK_ADDR, 32'h1);
    rchk(IRQ_STATUS_ADDR, 32'h1);
    apb(1, IRQ_STATUS_ADDR, 32'h1);
    `WAIT(!irq)
  endtask
  task automatic t_quad;
    apb(1, MODE_ADDR, 32'h40);
    `WAIT(ch2_use_external)
    for (int i = 0; i < 8; i++)
    begin
      `PULSE(step, i < 4 ? 2'h1 : 2'h2)
      `WAIT(i < 4 ? ch2_count_up : ch2_count_down)
    end
    `PULSE(ch2_prescaled_tick, 1'b1)
    repeat (8)
    begin
      @(negedge clk_sys);
      `CHK(ch2_count_up, 1'b0)
    end
    `PULSE(step, 2'h3)
    apb(1, IRQ_MASK_ADDR, 32'h2);
    `WAIT(irq)
    rchk(IRQ_STATUS_ADDR, 32'h2);
    apb(1, IRQ_STATUS_ADDR, 32'h2);
    `WAIT(!irq)
  endtask
  task automatic t_pwm;
    apb(1, MODE_ADDR, 32'h1F);
    `WAIT(pulse_pin_oe == 5'h1F)
    `PULSE(compare_match_a, 5'h1F)
    `WAIT(pulse_pin == 5'h1F)
    `PULSE(compare_match_b, 5'h08)
    `WAIT(pulse_pin == 5'h17)
    @(posedge clk_sys);
    combination_mode <= 2'h2;
    `WAIT(pulse_pin_oe == 5'h07)
    `PULSE(standby, 1'b1)
    rchk(MODE_ADDR, 32'h80);
    rchk(SYNC_ADDR, 32'hE0);
    `WAIT(pulse_pin_oe == 5'h00)
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1;
    t_regs();
    t_sync();
    t_irq();
    t_quad();
    t_pwm();
    final_report();
  end
endmodule
`default_nettype wire
